// >>> burst_sram.sv
// Pipelined burst SRAM with late write and byte masking
`timescale 1ns/1ps
module burst_sram
  import burst_sram_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  clock_qualify_n,
  input  wire logic                  chip_select_a_n,
  input  wire logic                  chip_select_b,
  input  wire logic                  chip_select_c_n,
  input  wire logic                  load_advance,
  input  wire logic                  write_enable_n,
  input  wire logic [BYTE_LANES-1:0] byte_select_n,
  input  wire logic                  output_enable_n,
  input  wire logic                  burst_order,
  input  wire logic                  sleep_request,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     data_in,
  input  wire logic [PAR_W-1:0]      parity_bus_in,
  output logic      [DATA_W-1:0]     data_out,
  output logic      [PAR_W-1:0]      parity_bus_out,
  output logic                       data_oe,
  output logic                       sleeping
);

  localparam int LANE_W = DATA_W / BYTE_LANES;
  localparam int WORD_W = DATA_W + PAR_W;

  logic [WORD_W-1:0] mem [DEPTH];

  // Command decode
  logic qualified;
  logic all_selected;
  logic start_cmd;
  logic advance_cmd;
  logic desel_cmd;
  logic awake;

  power_state_e      pwr_reg;
  logic [SLEEP_CNT_W-1:0] pwr_cnt_reg;

  assign awake        = (pwr_reg == PWR_AWAKE);
  assign qualified    = !clock_qualify_n && awake;
  assign all_selected = !chip_select_a_n && chip_select_b
                        && !chip_select_c_n;
  assign start_cmd    = qualified && !load_advance && all_selected;
  assign desel_cmd    = qualified && !load_advance && !all_selected;
  assign advance_cmd  = qualified && load_advance;

  // Burst context
  logic [ADDR_W-1:0]  base_addr_reg;
  logic [BURST_W-1:0] step_reg;
  logic               active_reg;
  logic               is_write_reg;
  logic [BURST_W-1:0] low_addr;
  logic [ADDR_W-1:0]  cur_addr;

  // Order is sampled at each load so a strap change mid-burst
  // cannot scramble a sequence already under way
  logic order_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      order_reg <= BURST_INTERLEAVED;
    else if (start_cmd)
      order_reg <= burst_order;
  end

  burst_addr_step u_step
  (
    .start_low (base_addr_reg[BURST_W-1:0]),
    .step      (step_reg),
    .order     (order_reg),
    .addr_low  (low_addr)
  );

  assign cur_addr = {base_addr_reg[ADDR_W-1:BURST_W], low_addr};

  // Start address and access type, captured at load
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      base_addr_reg <= '0;
      is_write_reg  <= 1'b0;
    end
    else if (awake && start_cmd)
    begin
      base_addr_reg <= addr;
      is_write_reg  <= !write_enable_n;
    end
  end

  // Burst activity and step count
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_reg   <= STEP_RESET;
      active_reg <= 1'b0;
    end
    else if (!awake)
    begin
      active_reg <= 1'b0;
    end
    else if (start_cmd)
    begin
      step_reg   <= STEP_RESET;
      active_reg <= 1'b1;
    end
    else if (desel_cmd)
    begin
      active_reg <= 1'b0;
    end
    else if (advance_cmd && active_reg)
    begin
      step_reg <= BURST_W'(step_reg + STEP_ONE);
    end
  end

  // Issue stage: the access performed at this qualified edge
  logic               issue_valid;
  logic               issue_write;
  logic [ADDR_W-1:0]  issue_addr;

  always_comb
  begin
    issue_valid = 1'b0;
    issue_write = 1'b0;
    issue_addr  = addr;
    if (start_cmd)
    begin
      issue_valid = 1'b1;
      issue_write = !write_enable_n;
      issue_addr  = addr;
    end
    else if (advance_cmd && active_reg)
    begin
      issue_valid = 1'b1;
      issue_write = is_write_reg;
      issue_addr  = {base_addr_reg[ADDR_W-1:BURST_W],
                     BURST_W'(low_addr)};
    end
  end

  // Advanced address for the burst step in progress
  logic [BURST_W-1:0] next_low;

  burst_addr_step u_next
  (
    .start_low (base_addr_reg[BURST_W-1:0]),
    .step      (BURST_W'(step_reg + STEP_ONE)),
    .order     (order_reg),
    .addr_low  (next_low)
  );

  logic [ADDR_W-1:0] burst_addr;
  assign burst_addr = {base_addr_reg[ADDR_W-1:BURST_W], next_low};

  // Pipeline stage 1: command accepted last qualified edge
  logic              p1_valid_reg;
  logic              p1_write_reg;
  logic [ADDR_W-1:0] p1_addr_reg;
  // Pipeline stage 2: write awaiting data
  logic              p2_write_reg;
  logic [ADDR_W-1:0] p2_addr_reg;
  logic [BYTE_LANES-1:0] p2_bsel_n_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p1_valid_reg <= 1'b0;
      p1_write_reg <= 1'b0;
    end
    else if (!awake)
    begin
      p1_valid_reg <= 1'b0;
      p1_write_reg <= 1'b0;
    end
    else if (qualified)
    begin
      p1_valid_reg <= issue_valid;
      p1_write_reg <= issue_valid && issue_write;
    end
  end

  // Address of the access in stage 1
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      p1_addr_reg <= '0;
    else if (qualified)
      p1_addr_reg <= (advance_cmd && active_reg) ? burst_addr
                                                 : issue_addr;
  end

  // Byte selects are sampled at the first qualified edge after the write command, one edge ahead of its data
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p2_write_reg  <= 1'b0;
      p2_addr_reg   <= '0;
      p2_bsel_n_reg <= '1;
    end
    else if (!awake)
    begin
      p2_write_reg <= 1'b0;
    end
    else if (qualified)
    begin
      p2_write_reg  <= p1_write_reg;
      p2_addr_reg   <= p1_addr_reg;
      p2_bsel_n_reg <= byte_select_n;
    end
  end

  // Late write: data taken at second rise after command
  always_ff @(posedge mclk)
  begin
    if (qualified && p2_write_reg)
    begin
      for (int b = 0; b < BYTE_LANES; b++)
      begin
        if (!p2_bsel_n_reg[b])
        begin
          mem[p2_addr_reg][b*LANE_W +: LANE_W] <=
            data_in[b*LANE_W +: LANE_W];
          mem[p2_addr_reg][DATA_W + b] <= parity_bus_in[b];
        end
      end
    end
  end

  // Output register and output enable pipeline
  logic              rd_drive_reg;
  logic [WORD_W-1:0] rd_word;

  assign rd_word = mem[p1_addr_reg];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_out       <= '0;
      parity_bus_out <= '0;
      rd_drive_reg   <= 1'b0;
    end
    else if (!awake)
    begin
      rd_drive_reg <= 1'b0;
    end
    else if (qualified)
    begin
      rd_drive_reg <= p1_valid_reg && !p1_write_reg;
      if (p1_valid_reg && !p1_write_reg)
      begin
        data_out       <= rd_word[DATA_W-1:0];
        parity_bus_out <= rd_word[WORD_W-1:DATA_W];
      end
    end
  end

  // Output enable is gated by internal control
  assign data_oe = rd_drive_reg && !output_enable_n;

  // Sleep entry and exit sequencing
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_reg     <= PWR_AWAKE;
      pwr_cnt_reg <= '0;
    end
    else
    begin
      unique case (pwr_reg)
        PWR_AWAKE:
          if (sleep_request)
          begin
            pwr_reg     <= PWR_ENTERING;
            pwr_cnt_reg <= SLEEP_CNT_W'(SLEEP_ENTRY_CYCLES - 1);
          end
        PWR_ENTERING:
          if (pwr_cnt_reg == '0)
            pwr_reg <= PWR_ASLEEP;
          else
            pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
        PWR_ASLEEP:
          if (!sleep_request)
          begin
            pwr_reg     <= PWR_WAKING;
            pwr_cnt_reg <= SLEEP_CNT_W'(SLEEP_RECOVERY_CYC - 1);
          end
        PWR_WAKING:
          if (pwr_cnt_reg == '0)
            pwr_reg <= PWR_AWAKE;
          else
            pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
      endcase
    end
  end

  // Sleep flag registered so the status pin cannot glitch on decode
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      sleeping <= 1'b0;
    else
      sleeping <= (pwr_reg == PWR_ENTERING && pwr_cnt_reg == '0)
                  || (pwr_reg == PWR_ASLEEP && sleep_request);
  end

endmodule // burst_sram

// >>> burst_sram_pkg.sv
// Package of widths, encodings and timing counts for the burst SRAM block
package burst_sram_pkg;

  localparam int ADDR_W       = 10;
  localparam int BYTE_LANES   = 4;
  localparam int DATA_W       = 32;
  localparam int PAR_W        = BYTE_LANES;
  localparam int DEPTH        = 1 << ADDR_W;
  localparam int BURST_W      = 2;

  localparam int CLK_PERIOD_NS       = 100;
  localparam int SLEEP_ENTRY_CYCLES  = 2;
  localparam int SLEEP_RECOVERY_CYC  = 2;
  localparam int SLEEP_CNT_W         = 2;

  localparam logic BURST_LINEAR      = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;

  localparam logic [BURST_W-1:0] STEP_RESET = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE   = 2'h1;

  typedef enum logic [1:0]
  {
    PWR_AWAKE    = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_ASLEEP   = 2'b10,
    PWR_WAKING   = 2'b11
  } power_state_e;

endpackage

// >>> burst_addr_step.sv
// Burst address sequencer for the two lowest address bits
`timescale 1ns/1ps
module burst_addr_step
  import burst_sram_pkg::*;
(
  input  wire logic [BURST_W-1:0] start_low,
  input  wire logic [BURST_W-1:0] step,
  input  wire logic               order,
  output logic      [BURST_W-1:0] addr_low
);

  always_comb
  begin
    if (order == BURST_INTERLEAVED)
      addr_low = start_low ^ step;
    else
      addr_low = BURST_W'(start_low + step);
  end

endmodule // burst_addr_step

// >>> burst_sram_asserts.sv
// Port checks for the burst SRAM
`timescale 1ns/1ps
module burst_sram_asserts
  import burst_sram_pkg::*;
(
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              clock_qualify_n,
  input wire logic              chip_select_a_n,
  input wire logic              chip_select_b,
  input wire logic              chip_select_c_n,
  input wire logic              load_advance,
  input wire logic              write_enable_n,
  input wire logic              output_enable_n,
  input wire logic              sleep_request,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic              sleeping
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic sel;
  logic go;
  assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign go = !clock_qualify_n && !sleep_request && !sleeping;
  sequence rd_s;
    go && sel && !load_advance && write_enable_n;
  endsequence
  sequence wr_s;
    go && sel && !load_advance && !write_enable_n;
  endsequence
  freeze_hold_a:
    assert property (clock_qualify_n |=> $stable(data_out))
    else $error("read data moved on ignored edge");
  read_drive_a:
    assert property (rd_s ##1 go |=> data_oe == !output_enable_n)
    else $error("read data not driven");
  burst_drive_a:
    assert property (rd_s ##1 (go && load_advance) ##1 go
      |=> data_oe == !output_enable_n)
    else $error("burst read not driven");
  write_float_a:
    assert property (wr_s ##1 go |=> !data_oe)
    else $error("driven in write data cycle");
  desel_float_a:
    assert property ((go && !sel && !load_advance) ##1 go |=> !data_oe)
    else $error("driven after deselect");
  sleep_float_a:
    assert property (sleeping |-> !data_oe)
    else $error("driven while asleep");
  sleep_enter_a:
    assert property ($rose(sleep_request) |-> ##[1:3] sleeping)
    else $error("sleep not entered");
  reset_float_a:
    assert property (disable iff (1'h0) !arst_n |-> !data_oe && !sleeping)
    else $error("active during reset");
  cover property (rd_s ##1 go);
  cover property (wr_s ##1 go);
  cover property (sleeping);
endmodule // burst_sram_asserts

// >>> sram_ctl_model.sv
// Controller model driving the burst SRAM
`timescale 1ns/1ps
module sram_ctl_model
  import burst_sram_pkg::*;
(
  input  wire logic                  mclk,
  output logic                       clock_qualify_n,
  output logic                       chip_select_a_n,
  output logic                       chip_select_b,
  output logic                       chip_select_c_n,
  output logic                       load_advance,
  output logic                       write_enable_n,
  output logic      [BYTE_LANES-1:0] byte_select_n,
  output logic                       output_enable_n,
  output logic                       burst_order,
  output logic                       sleep_request,
  output logic      [ADDR_W-1:0]     addr,
  output logic      [PAR_W+DATA_W-1:0] wdata,
  output logic                       rd_due
);
  localparam int W = PAR_W + DATA_W;
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] exp_q [$];
  logic [W-1:0] d1, d2;
  logic [ADDR_W-1:0] base, a1, a2;
  logic [3:0] b1, b2;
  logic [1:0] stp;
  logic act, bwr, w1, w2, rd_cmd, rd_p;
  initial
  begin
    {clock_qualify_n, chip_select_b, load_advance, burst_order} = 4'h0;
    {sleep_request, output_enable_n, rd_cmd, rd_p, rd_due} = 5'h0;
    {chip_select_a_n, chip_select_c_n, write_enable_n} = 3'h7;
    {act, w1, w2, stp, base, addr, wdata} = '0;
    byte_select_n = 4'hF;
  end
  always @(posedge mclk)
  begin
    rd_due <= !clock_qualify_n & rd_p;
    if (!clock_qualify_n)
      rd_p <= rd_cmd;
  end
  task automatic op(input logic adv, input logic wr, input logic sel,
    input logic [ADDR_W-1:0] a, input logic [3:0] bs, input logic [W-1:0] d);
    logic [ADDR_W-1:0] ea;
    logic iw;
    begin
      ea = base;
      iw = bwr;
      if (adv)
      begin
        stp = stp + STEP_ONE;
        ea[1:0] = burst_order ? base[1:0] ^ stp : base[1:0] + stp;
      end
      else
      begin
        base = a;
        ea = a;
        stp = STEP_RESET;
        act = sel;
        bwr = wr;
        iw = wr;
      end
      @(posedge mclk);
      clock_qualify_n <= 1'h0;
      load_advance <= adv;
      write_enable_n <= !wr;
      chip_select_a_n <= !sel;
      chip_select_b <= sel;
      chip_select_c_n <= !sel;
      addr <= a;
      rd_cmd <= act & !iw;
      if (act & !iw)
        exp_q.push_back(mem[ea]);
      byte_select_n <= w1 ? b1 : 4'hF;
      wdata <= w2 ? d2 : ~wdata;
      for (int b = 0; b < BYTE_LANES; b++)
        if (w2 && !b2[b])
        begin
          mem[a2][8*b +: 8] = d2[8*b +: 8];
          mem[a2][DATA_W+b] = d2[DATA_W+b];
        end
      {w2, a2, b2, d2} = {w1, a1, b1, d1};
      {w1, a1, b1, d1} = {act & iw, ea, bs, d};
    end
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'h0, 1'h0, 1'h0, '0, 4'hF, '0);
  endtask
  task automatic stall(input int n);
    @(posedge mclk);
    clock_qualify_n <= 1'h1;
    repeat (n - 1) @(posedge mclk);
  endtask
  task automatic cfg(input logic oe_n, input logic ord, input logic slp);
    @(posedge mclk);
    output_enable_n <= oe_n;
    burst_order <= ord;
    sleep_request <= slp;
  endtask
endmodule // sram_ctl_model

// >>> pipelined_burst_sram_access_tb_top.sv
// Testbench for the burst SRAM
`timescale 1ns/1ps
module pipelined_burst_sram_access_tb_top
  import burst_sram_pkg::*;
;
  logic mclk, arst_n, clock_qualify_n, chip_select_a_n, chip_select_b;
  logic chip_select_c_n, load_advance, write_enable_n, output_enable_n;
  logic burst_order, sleep_request, data_oe, sleeping, rd_due;
  logic [BYTE_LANES-1:0] byte_select_n;
  logic [ADDR_W-1:0] addr, a;
  logic [1:0] rs;
  logic [PAR_W+DATA_W-1:0] wdata, e;
  logic [DATA_W-1:0] data_out;
  logic [PAR_W-1:0] parity_bus_out;
  int seed = 32'h2b6a31a5;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  burst_sram dut (.mclk, .arst_n, .clock_qualify_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .load_advance, .write_enable_n,
    .byte_select_n, .output_enable_n, .burst_order, .sleep_request, .addr,
    .data_in(wdata[DATA_W-1:0]), .parity_bus_in(wdata[PAR_W+DATA_W-1:DATA_W]),
    .data_out, .parity_bus_out, .data_oe, .sleeping);
  sram_ctl_model u_ctl (.mclk, .clock_qualify_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .load_advance, .write_enable_n,
    .byte_select_n, .output_enable_n, .burst_order, .sleep_request, .addr,
    .wdata, .rd_due);
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [PAR_W+DATA_W-1:0] rnd();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction
  task automatic chk(input string what, input logic [PAR_W+DATA_W:0] seen,
    input logic [PAR_W+DATA_W:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge mclk)
    if (rd_due === 1'h1)
    begin
      e = u_ctl.exp_q.pop_front();
      chk("read", {data_oe, parity_bus_out, data_out}, {~output_enable_n, e});
    end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    arst_n = 1'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'h1;
    for (int o = 0; o < 2; o++)
    begin
      u_ctl.cfg(1'($random(seed)), o[0], 1'h0);
      a = 10'($random(seed));
      for (int i = 0; i < 4; i++)
      begin
        rs = 2'($random(seed));
        u_ctl.op(i > 0, i == 0 || rs[0], i == 0 || rs[1], a, 4'h0,
          rnd());
      end
      u_ctl.idle(3);
      for (int i = 0; i < 4; i++)
      begin
        rs = 2'($random(seed));
        u_ctl.op(i > 0, i > 0 && rs[0], i == 0 || rs[1], a, 4'hF,
          rnd());
        if (i == o)
          u_ctl.stall(3);
      end
      u_ctl.idle(3);
    end
    u_ctl.op(1'h0, 1'h1, 1'h1, a, 4'($random(seed)), rnd());
    u_ctl.idle(3);
    u_ctl.cfg(1'h1, 1'h0, 1'h0);
    u_ctl.op(1'h0, 1'h0, 1'h1, a, 4'hF, rnd());
    u_ctl.idle(2);
    u_ctl.cfg(1'h0, 1'h0, 1'h1);
    repeat (8) @(posedge mclk);
    u_ctl.cfg(1'h0, 1'h0, 1'h0);
    u_ctl.idle(4);
    u_ctl.op(1'h0, 1'h0, 1'h1, a, 4'hF, rnd());
    u_ctl.idle(3);
    final_report();
  end
endmodule // pipelined_burst_sram_access_tb_top

bind burst_sram burst_sram_asserts u_chk (.mclk, .arst_n, .clock_qualify_n,
  .chip_select_a_n, .chip_select_b, .chip_select_c_n, .load_advance,
  .write_enable_n, .output_enable_n, .sleep_request, .data_out, .data_oe,
  .sleeping);
